// ---- include/sxt_pkg.sv ----
// Shared constants and types of the subtract/xor/trap execute unit
package sxt_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_CTL    = 8'h04;
  localparam logic [7:0] A_INSTR  = 8'h08;
  localparam logic [7:0] A_DEST   = 8'h0C;
  localparam logic [7:0] A_SRC    = 8'h10;
  localparam logic [7:0] A_PSW    = 8'h14;
  localparam logic [7:0] A_RESULT = 8'h18;
  localparam logic [7:0] A_SP     = 8'h1C;
  localparam logic [7:0] A_CSP    = 8'h20;
  localparam logic [7:0] A_IP     = 8'h24;
  localparam logic [7:0] A_VECTOR_SEGMENT   = 8'h28;
  localparam logic [7:0] A_DECODE = 8'h2C;
  localparam logic [7:0] A_FRAME0 = 8'h30;
  localparam logic [7:0] A_FRAME1 = 8'h34;
  localparam logic [7:0] A_FRAME2 = 8'h38;
  // Command and status bits
  localparam int CMD_START = 0;
  localparam int ST_BUSY   = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_ILL    = 2;
  // cpu_control_one fields
  localparam int CTL_SEGMENTATION_DISABLE = 0;
  localparam int CTL_VSP_LO = 1;
  localparam int CTL_W      = 3;
  // Flag positions in processor_status_word
  localparam int F_N = 0;
  localparam int F_C = 1;
  localparam int F_V = 2;
  localparam int F_Z = 3;
  localparam int F_E = 4;
  // Opcode groups (high nibble) and forms (low nibble, bit0 = byte)
  localparam logic [3:0] OPG_SUB_CARRY_WORD    = 4'h3;
  localparam logic [3:0] OPG_XOR     = 4'h5;
  localparam logic [3:0] FRM_RR      = 4'h0;
  localparam logic [3:0] FRM_SHORT   = 4'h8;
  localparam logic [3:0] FRM_MEMREG  = 4'h4;
  localparam logic [3:0] FRM_LIMM    = 4'h6;
  localparam logic [3:0] FRM_REGMEM  = 4'h2;
  localparam logic [7:0] OP_TRAP     = 8'h9B;
  localparam logic [15:0] MIN_WORD   = 16'h8000;
  localparam logic [7:0]  MIN_BYTE   = 8'h80;
  localparam logic [15:0] SP_STEP    = 16'h0002;
  localparam logic [2:0]  LEN_SHORT  = 3'h2;
  localparam logic [2:0]  LEN_LONG   = 3'h4;
  // Source operand modes
  typedef enum logic [2:0] {
    M_REG = 3'h0, M_IMM3 = 3'h1, M_IND_INC = 3'h2, M_IND = 3'h3,
    M_MEM_DST = 3'h4, M_IMM_LONG = 3'h5, M_MEM_SRC = 3'h6, M_NONE = 3'h7
  } sxt_mode_type;
  // Sequencer states
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_EXEC = 5'h02, S_PSW = 5'h04, S_CSP = 5'h08, S_IP = 5'h10
  } sxt_state_type;
endpackage

// ---- hw/sxt_decode.sv ----
// Opcode decoder and subtract/xor datapath
`timescale 1ns/10ps
module sxt_decode (
  // Instruction and operands
  input  wire logic [31:0]          instr,
  input  wire logic [15:0]          dest_val,
  input  wire logic [15:0]          src_val,
  input  wire logic [15:0]          psw_in,
  // Decode results
  output logic                      valid,
  output logic                      is_trap,
  output logic                      is_byte,
  output sxt_pkg::sxt_mode_type     mode,
  output logic [2:0]                length,
  output logic [6:0]                trap_num,
  // Execute results
  output logic [15:0]               result,
  output logic [15:0]               psw_out
);
  logic [3:0]  grp;
  logic [3:0]  frm;
  logic        sub_op;
  logic        form_ok;
  logic [15:0] s;
  logic [15:0] d;
  logic [16:0] dw;
  logic [8:0]  db;
  logic [15:0] r;
  logic        msb;

  // Opcode and operand mode decode
  always_comb begin
    grp      = instr[7:4];
    frm      = {instr[3:1], 1'b0};
    is_byte  = instr[0];
    sub_op   = (grp == sxt_pkg::OPG_SUB_CARRY_WORD);
    trap_num = instr[15:9];
    is_trap  = (instr[7:0] == sxt_pkg::OP_TRAP) && !instr[8];
    form_ok  = 1'b1;
    length   = sxt_pkg::LEN_LONG;
    case (frm)
      sxt_pkg::FRM_RR: begin
        mode   = sxt_pkg::M_REG;
        length = sxt_pkg::LEN_SHORT;
      end
      sxt_pkg::FRM_SHORT: begin
        length = sxt_pkg::LEN_SHORT;
        if (!instr[11]) mode = sxt_pkg::M_IMM3;
        else if (instr[10]) mode = sxt_pkg::M_IND_INC;
        else mode = sxt_pkg::M_IND;
      end
      sxt_pkg::FRM_MEMREG: mode = sxt_pkg::M_MEM_DST;
      sxt_pkg::FRM_LIMM:   mode = sxt_pkg::M_IMM_LONG;
      sxt_pkg::FRM_REGMEM: mode = sxt_pkg::M_MEM_SRC;
      default: begin
        mode    = sxt_pkg::M_NONE;
        form_ok = 1'b0;
      end
    endcase
    valid = is_trap || (form_ok && (sub_op || grp == sxt_pkg::OPG_XOR));
    if (is_trap) begin
      mode   = sxt_pkg::M_NONE;
      length = sxt_pkg::LEN_SHORT;
    end
  end

  // Operand selection and arithmetic
  always_comb begin
    case (mode)
      sxt_pkg::M_IMM3:     s = {13'h0000, instr[10:8]};
      sxt_pkg::M_IMM_LONG: s = is_byte ? {8'h00, instr[23:16]} : instr[31:16];
      default:             s = src_val;
    endcase
    if (is_byte) s = {8'h00, s[7:0]};
    d  = is_byte ? {8'h00, dest_val[7:0]} : dest_val;
    dw = {1'b0, d} - {1'b0, s} - {16'h0000, psw_in[sxt_pkg::F_C]};
    db = {1'b0, d[7:0]} - {1'b0, s[7:0]} - {8'h00, psw_in[sxt_pkg::F_C]};
    psw_out = psw_in;
    if (sub_op) begin
      r = is_byte ? {8'h00, db[7:0]} : dw[15:0];
      psw_out[sxt_pkg::F_C] = is_byte ? db[8] : dw[16];
      psw_out[sxt_pkg::F_V] = is_byte ?
        (d[7] != s[7]) && (r[7] != d[7]) : (d[15] != s[15]) && (r[15] != d[15]);
      psw_out[sxt_pkg::F_Z] = (r == 16'h0000) && psw_in[sxt_pkg::F_Z];
    end else begin
      r = d ^ s;
      psw_out[sxt_pkg::F_C] = 1'b0;
      psw_out[sxt_pkg::F_V] = 1'b0;
      psw_out[sxt_pkg::F_Z] = (r == 16'h0000);
    end
    msb = is_byte ? r[7] : r[15];
    psw_out[sxt_pkg::F_N] = msb;
    psw_out[sxt_pkg::F_E] = is_byte ? (s[7:0] == sxt_pkg::MIN_BYTE)
                                    : (s == sxt_pkg::MIN_WORD);
    result = is_byte ? {dest_val[15:8], r[7:0]} : r;
  end
endmodule // sxt_decode

// ---- hw/sxt_exec.sv ----
// APB-controlled execute unit for carry subtract, exclusive OR and software trap
`timescale 1ns/10ps
module sxt_exec (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  // Whole state of the unit
  typedef struct packed {
    sxt_pkg::sxt_state_type st;
    logic [31:0]            instr;
    logic [15:0]            dest;
    logic [15:0]            src;
    logic [15:0]            processor_status_word;
    logic [15:0]            result;
    logic [15:0]            sp;
    logic [15:0]            code_segment_pointer;
    logic [15:0]            ip;
    logic [15:0]            vector_segment;
    logic [2:0]             ctl;
    logic                   done;
    logic                   ill;
    logic [1:0]             fcnt;
    logic [2:0][31:0]       frame;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } sxt_regs_type;

  sxt_regs_type            q_r;
  sxt_regs_type            q_nxt;

  logic                    dec_valid;
  logic                    dec_trap;
  logic                    dec_byte;
  sxt_pkg::sxt_mode_type   dec_mode;
  logic [2:0]              dec_len;
  logic [6:0]              dec_tnum;
  logic [15:0]             dec_result;
  logic [15:0]             dec_psw;
  logic                    acc_done;
  logic                    busy;
  logic [15:0]             sp_dec;
  logic [15:0]             trap_vec;
  logic [1:0]              vsp;

  // Tells whether an offset is a mapped register
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      sxt_pkg::A_CMD, sxt_pkg::A_CTL, sxt_pkg::A_INSTR, sxt_pkg::A_DEST,
      sxt_pkg::A_SRC, sxt_pkg::A_PSW, sxt_pkg::A_RESULT, sxt_pkg::A_SP,
      sxt_pkg::A_CSP, sxt_pkg::A_IP, sxt_pkg::A_VECTOR_SEGMENT, sxt_pkg::A_DECODE,
      sxt_pkg::A_FRAME0, sxt_pkg::A_FRAME1, sxt_pkg::A_FRAME2: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // Tells whether an offset may be written by software
  function automatic logic reg_writable(input logic [7:0] a);
    case (a)
      sxt_pkg::A_CMD, sxt_pkg::A_CTL, sxt_pkg::A_INSTR, sxt_pkg::A_DEST,
      sxt_pkg::A_SRC, sxt_pkg::A_PSW, sxt_pkg::A_SP, sxt_pkg::A_CSP,
      sxt_pkg::A_IP, sxt_pkg::A_VECTOR_SEGMENT: reg_writable = 1'b1;
      default: reg_writable = 1'b0;
    endcase
  endfunction

  // Decoder and datapath
  sxt_decode u_dec (
    .instr    (q_r.instr),
    .dest_val (q_r.dest),
    .src_val  (q_r.src),
    .psw_in   (q_r.processor_status_word),
    .valid    (dec_valid),
    .is_trap  (dec_trap),
    .is_byte  (dec_byte),
    .mode     (dec_mode),
    .length   (dec_len),
    .trap_num (dec_tnum),
    .result   (dec_result),
    .psw_out  (dec_psw)
  );

  // Helper terms for bus and trap sequencing
  always_comb begin
    acc_done = psel && penable && q_r.pready;
    busy     = (q_r.st != sxt_pkg::S_IDLE);
    sp_dec   = q_r.sp - sxt_pkg::SP_STEP;
    vsp      = q_r.ctl[sxt_pkg::CTL_VSP_LO +: 2];
    trap_vec = 16'({dec_tnum, 2'b00}) << vsp;
  end

  // Next-state logic: bus slave, register writes and sequencer
  always_comb begin
    q_nxt         = q_r;
    q_nxt.pready  = 1'b0;
    q_nxt.pslverr = 1'b0;
    q_nxt.prdata  = 32'h0000_0000;

    // Setup phase: prepare answer for the access phase
    if (psel && !penable && !q_r.pready) begin
      q_nxt.pready  = 1'b1;
      q_nxt.pslverr = !reg_hit(paddr) || (pwrite && busy && reg_writable(paddr));
      if (!pwrite) begin
        case (paddr)
          sxt_pkg::A_CMD:    q_nxt.prdata = {29'h0000_0000, q_r.ill, q_r.done, busy};
          sxt_pkg::A_CTL:    q_nxt.prdata = {29'h0000_0000, q_r.ctl};
          sxt_pkg::A_INSTR:  q_nxt.prdata = q_r.instr;
          sxt_pkg::A_DEST:   q_nxt.prdata = {16'h0000, q_r.dest};
          sxt_pkg::A_SRC:    q_nxt.prdata = {16'h0000, q_r.src};
          sxt_pkg::A_PSW:    q_nxt.prdata = {16'h0000, q_r.processor_status_word};
          sxt_pkg::A_RESULT: q_nxt.prdata = {16'h0000, q_r.result};
          sxt_pkg::A_SP:     q_nxt.prdata = {16'h0000, q_r.sp};
          sxt_pkg::A_CSP:    q_nxt.prdata = {16'h0000, q_r.code_segment_pointer};
          sxt_pkg::A_IP:     q_nxt.prdata = {16'h0000, q_r.ip};
          sxt_pkg::A_VECTOR_SEGMENT:   q_nxt.prdata = {16'h0000, q_r.vector_segment};
          sxt_pkg::A_DECODE: q_nxt.prdata = {19'h0_0000, q_r.fcnt,
                                             dec_len, dec_mode, dec_byte, dec_trap,
                                             dec_valid, q_r.instr[9:8]};
          sxt_pkg::A_FRAME0: q_nxt.prdata = q_r.frame[0];
          sxt_pkg::A_FRAME1: q_nxt.prdata = q_r.frame[1];
          sxt_pkg::A_FRAME2: q_nxt.prdata = q_r.frame[2];
          default:           q_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end

    // Access phase: writes take effect, refused while busy
    if (acc_done && pwrite && !busy) begin
      case (paddr)
        sxt_pkg::A_CMD: begin
          if (pwdata[sxt_pkg::CMD_START]) begin
            q_nxt.st   = sxt_pkg::S_EXEC;
            q_nxt.done = 1'b0;
            q_nxt.ill  = 1'b0;
          end
        end
        sxt_pkg::A_CTL:   q_nxt.ctl   = pwdata[sxt_pkg::CTL_W-1:0];
        sxt_pkg::A_INSTR: q_nxt.instr = pwdata;
        sxt_pkg::A_DEST:  q_nxt.dest  = pwdata[15:0];
        sxt_pkg::A_SRC:   q_nxt.src   = pwdata[15:0];
        sxt_pkg::A_PSW:   q_nxt.processor_status_word   = pwdata[15:0];
        sxt_pkg::A_SP:    q_nxt.sp    = pwdata[15:0];
        sxt_pkg::A_CSP:   q_nxt.code_segment_pointer   = pwdata[15:0];
        sxt_pkg::A_IP:    q_nxt.ip    = pwdata[15:0];
        sxt_pkg::A_VECTOR_SEGMENT:  q_nxt.vector_segment  = pwdata[15:0];
        default: ;
      endcase
    end

    // Execution sequencer
    case (q_r.st)
      sxt_pkg::S_IDLE: ;
      sxt_pkg::S_EXEC: begin
        if (!dec_valid) begin
          q_nxt.ill  = 1'b1;
          q_nxt.done = 1'b1;
          q_nxt.st   = sxt_pkg::S_IDLE;
        end else if (dec_trap) begin
          q_nxt.fcnt  = 2'b00;
          q_nxt.frame = '0;
          q_nxt.st    = sxt_pkg::S_PSW;
        end else begin
          q_nxt.result = dec_result;
          q_nxt.dest   = dec_result;
          q_nxt.processor_status_word    = dec_psw;
          q_nxt.done   = 1'b1;
          q_nxt.st     = sxt_pkg::S_IDLE;
        end
      end
      sxt_pkg::S_PSW: begin
        // Status word saved untouched, priority included
        q_nxt.sp       = sp_dec;
        q_nxt.frame[0] = {sp_dec, q_r.processor_status_word};
        q_nxt.fcnt     = 2'b01;
        if (!q_r.ctl[sxt_pkg::CTL_SEGMENTATION_DISABLE]) q_nxt.st = sxt_pkg::S_CSP;
        else q_nxt.st = sxt_pkg::S_IP;
      end
      sxt_pkg::S_CSP: begin
        q_nxt.sp       = sp_dec;
        q_nxt.frame[1] = {sp_dec, q_r.code_segment_pointer};
        q_nxt.fcnt     = 2'b10;
        q_nxt.st       = sxt_pkg::S_IP;
      end
      sxt_pkg::S_IP: begin
        // Segment loaded, pointer pushed, vector taken; no source marker kept
        q_nxt.code_segment_pointer             = q_r.vector_segment;
        q_nxt.sp              = sp_dec;
        q_nxt.frame[q_r.fcnt] = {sp_dec, q_r.ip};
        q_nxt.fcnt            = q_r.fcnt + 2'b01;
        q_nxt.ip              = trap_vec;
        q_nxt.done            = 1'b1;
        q_nxt.st              = sxt_pkg::S_IDLE;
      end
      default: q_nxt.st = sxt_pkg::S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r    <= '0;
      q_r.st <= sxt_pkg::S_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Bus outputs straight from flops
  always_comb begin
    prdata  = q_r.prdata;
    pready  = q_r.pready;
    pslverr = q_r.pslverr;
  end
endmodule // sxt_exec

// ---- verification/sxt_exec_props.sv ----
// Register port protocol checker for the execute unit
`timescale 1ns/10ps
module sxt_exec_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup phase waiting for its answer, and the answering access cycle
  sequence setup_s;
    psel && !penable && !pready;
  endsequence
  sequence answer_s;
    psel && penable && pready;
  endsequence
  // Read answers to the unmapped and the half-word places
  sequence rd_unmapped_s;
    answer_s ##0 (!pwrite && paddr > 8'h38);
  endsequence
  sequence rd_half_s;
    answer_s ##0 (!pwrite && paddr inside {[8'h0C:8'h28]});
  endsequence
  // Timing and idle level of the answer
  ready_after_setup_a: assert property (setup_s |=> answer_s) // Single access cycle
    else $error("no answer one cycle after setup");
  ready_pulse_a: assert property (answer_s |=> !pready) // One-cycle ready
    else $error("ready held longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable) // Only in access
    else $error("ready outside an access phase");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) // Idle read bus
    else $error("read data not zero while idle");
  err_with_ready_a: assert property (pslverr |-> $rose(pready)) // Error with answer
    else $error("error flag outside an answer");
  // Decoding of the address map
  unmapped_err_a: assert property (answer_s ##0 (paddr > 8'h38) |-> pslverr) // Refusal
    else $error("unmapped address not refused");
  unmapped_rdata_a: assert property (rd_unmapped_s |-> prdata == 32'h0) // Zero data
    else $error("unmapped read returned data");
  half_word_a: assert property (rd_half_s |-> prdata[31:16] == 16'h0000) // Upper half
    else $error("upper half of a half-word register not zero");
  mapped_read_a: assert property (answer_s ##0 (!pwrite && paddr <= 8'h38 && paddr[1:0] == 2'b00)
    |-> !pslverr) // Aligned mapped read
    else $error("mapped read refused");
endmodule // sxt_exec_props

bind sxt_exec sxt_exec_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ---- verification/tb.sv ----
// Self-checking testbench for the execute unit
`timescale 1ns/10ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          mismatches = 0;
  int          cmp_count = 0;
  logic [31:0] rd;
  logic        er;
  // Device under test
  sxt_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // Clock of 10 ns
  always #5 pclk = ~pclk;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; answer taken at the edge where ready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk(32'h0, 32'h1, "no ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Load operands, start, wait for done
  task automatic run(input logic [31:0] ins, input logic [15:0] d, s, p);
    int n;
    apb(1, sxt_pkg::A_INSTR, ins); apb(1, sxt_pkg::A_DEST, {16'h0, d});
    apb(1, sxt_pkg::A_SRC, {16'h0, s}); apb(1, sxt_pkg::A_PSW, {16'h0, p});
    apb(1, sxt_pkg::A_CMD, 32'h1);
    n = 0;
    do begin
      apb(0, sxt_pkg::A_CMD, 32'h0);
      n++;
    end while (rd[sxt_pkg::ST_DONE] !== 1'b1 && n < 20);
    if (rd[sxt_pkg::ST_DONE] !== 1'b1) chk(32'h0, 32'h1, "no done");
  endtask
  // Reference arithmetic; byte operands ride in the upper byte
  function automatic logic [31:0] model(logic [31:0] ins, logic [15:0] d, s, p);
    logic [15:0] sv, a, b, r;
    logic [16:0] df;
    logic        w, c, v;
    w = !ins[0]; sv = s; c = 1'b0; v = 1'b0;
    if (ins[3:1] == 3'b100 && !ins[11]) sv = {13'h0, ins[10:8]};
    if (ins[3:1] == 3'b011) sv = w ? ins[31:16] : {8'h00, ins[23:16]};
    a = w ? d : {d[7:0], 8'h00};
    b = w ? sv : {sv[7:0], 8'h00};
    if (ins[7:4] == sxt_pkg::OPG_SUB_CARRY_WORD) begin
      df = {1'b0, a} - {1'b0, b} - (w ? 17'h1 : 17'h100) * p[sxt_pkg::F_C];
      r = df[15:0]; c = df[16]; v = (a[15] ^ b[15]) & (r[15] ^ a[15]);
      return {w ? r : {d[15:8], r[15:8]}, p[15:5], b == 16'h8000,
              r == 16'h0 && p[sxt_pkg::F_Z], v, c, r[15]};
    end
    r = a ^ b;
    return {w ? r : {d[15:8], r[15:8]}, p[15:5], b == 16'h8000, r == 16'h0, 2'b00, r[15]};
  endfunction
  // All subtract and xor opcodes, each with two of the four operand sets
  task automatic t_alu();
    logic [3:0]  frm [5] = '{4'h0, 4'h8, 4'h4, 4'h6, 4'h2};
    logic [15:0] dv  [4] = '{16'h0005, 16'h8000, 16'h1234, 16'h3480};
    logic [15:0] sv  [4] = '{16'h0005, 16'h0001, 16'h8000, 16'h0080};
    logic [15:0] pv  [4] = '{16'hA50A, 16'h5A00, 16'h0008, 16'hC308};
    logic [7:0]  b1  [3] = '{8'h35, 8'h3E, 8'h39};
    logic [31:0] ins, e;
    logic [2:0]  md;
    for (int k = 0; k < 80; k++) begin
      ins = {16'h80C3, b1[k % 3], (k / 40) ? 4'h5 : 4'h3, frm[(k / 2) % 5] | k[0]};
      md = ins[3:0] == 4'h0 ? 3'h0 : ins[3:0] == 4'h1 ? 3'h0 : ins[3:1] == 3'b010 ? 3'h4 :
           ins[3:1] == 3'b011 ? 3'h5 : ins[3:1] == 3'b001 ? 3'h6 :
           !ins[11] ? 3'h1 : ins[10] ? 3'h2 : 3'h3;
      run(ins, dv[k % 4], sv[k % 4], pv[k % 4]);
      e = model(ins, dv[k % 4], sv[k % 4], pv[k % 4]);
      chk(rd, 32'h2, "status");
      apb(0, sxt_pkg::A_DEST, 32'h0);
      chk(rd, {16'h0, e[31:16]}, "dest");
      apb(0, sxt_pkg::A_RESULT, 32'h0);
      chk(rd, {16'h0, e[31:16]}, "result");
      apb(0, sxt_pkg::A_PSW, 32'h0);
      chk(rd, {16'h0, e[15:0]}, "flags");
      apb(0, sxt_pkg::A_DECODE, 32'h0);
      chk({21'h0, rd[10:0]}, {21'h0, ins[3:1] == 3'b100 || ins[3:1] == 3'b000 ? 3'h2 : 3'h4,
          md, ins[0], 2'b01, ins[9:8]}, "decode");
    end
    $display("Test alu done");
  endtask
  // Trap with segmentation on and off and each vector spacing
  task automatic t_trap(input logic sg, input logic [1:0] spc, input logic [6:0] num);
    logic [15:0] sp;
    sp = sg ? 16'h00FC : 16'h00FA;
    apb(1, sxt_pkg::A_CTL, {29'h0, spc, sg}); apb(1, sxt_pkg::A_SP, 32'h0100);
    apb(1, sxt_pkg::A_CSP, 32'h0011); apb(1, sxt_pkg::A_IP, 32'h2468);
    apb(1, sxt_pkg::A_VECTOR_SEGMENT, 32'h0033);
    run({16'h0, num, 1'b0, sxt_pkg::OP_TRAP}, 16'h0, 16'h0, 16'h5A1F);
    apb(0, sxt_pkg::A_SP, 32'h0); chk(rd, {16'h0, sp}, "sp");
    apb(0, sxt_pkg::A_CSP, 32'h0); chk(rd, 32'h0033, "csp");
    apb(0, sxt_pkg::A_IP, 32'h0);
    chk(rd, {16'h0, 16'({num, 2'b00}) << spc}, "ip");
    apb(0, sxt_pkg::A_PSW, 32'h0); chk(rd, 32'h5A1F, "psw");
    apb(0, sxt_pkg::A_FRAME0, 32'h0); chk(rd, 32'h00FE5A1F, "frame0");
    apb(0, sxt_pkg::A_FRAME1, 32'h0);
    chk(rd, sg ? 32'h00FC2468 : 32'h00FC0011, "frame1");
    apb(0, sxt_pkg::A_FRAME2, 32'h0);
    chk(rd, sg ? 32'h0 : 32'h00FA2468, "frame2");
    apb(0, sxt_pkg::A_DECODE, 32'h0);
    chk({30'h0, rd[12:11]}, sg ? 32'h2 : 32'h3, "frames");
    $display("Test trap done");
  endtask
  // Reset values, refusals and illegal opcodes
  task automatic t_bus();
    for (int a = 0; a <= 8'h38; a += 4) begin
      // Opcode zero still decodes as a two-byte form in the decode view
      apb(0, 8'(a), 32'h0);
      chk(rd, 8'(a) == sxt_pkg::A_DECODE ? {21'h0, sxt_pkg::LEN_SHORT, 8'h00} : 32'h0, "reset value");
    end
    apb(0, 8'h3C, 32'h0); chk({31'h0, er}, 32'h1, "unmapped");
    apb(1, sxt_pkg::A_RESULT, 32'h1234); chk({31'h0, er}, 32'h0, "ro write");
    apb(0, sxt_pkg::A_RESULT, 32'h0); chk(rd, 32'h0, "ro kept");
    // A trap keeps the unit busy long enough for the next write to be refused
    apb(1, sxt_pkg::A_INSTR, {16'h0, 8'h00, sxt_pkg::OP_TRAP});
    apb(1, sxt_pkg::A_CMD, 32'h1); apb(1, sxt_pkg::A_DEST, 32'h7777);
    chk({31'h0, er}, 32'h1, "busy write");
    apb(0, sxt_pkg::A_DEST, 32'h0); chk(rd, 32'h0, "busy write dropped");
    run(32'h0000_003C, 16'h4321, 16'h1, 16'h0);
    chk(rd, 32'h6, "illegal");
    run(32'h0000_019B, 16'h4321, 16'h1, 16'h0);
    chk(rd, 32'h6, "bad trap");
    apb(0, sxt_pkg::A_DEST, 32'h0); chk(rd, 32'h4321, "dest kept");
    $display("Test bus done");
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_alu();
    t_trap(1'b0, 2'h0, 7'h7F);
    t_trap(1'b1, 2'h1, 7'h01);
    t_trap(1'b0, 2'h2, 7'h40);
    t_trap(1'b1, 2'h3, 7'h7F);
    close_out();
  end
endmodule // tb
